//--- src/pfsa_regs.vh
// register offsets, field positions and timing constants of the flash self-access block
`ifndef PFSA_REGS_VH
`define PFSA_REGS_VH
`define PFSA_ADDR_LOW_OFS    12'h000
`define PFSA_ADDR_HIGH_OFS   12'h004
`define PFSA_DATA_LOW_OFS    12'h008
`define PFSA_DATA_HIGH_OFS   12'h00c
`define PFSA_CONTROL_OFS     12'h010
`define PFSA_KEY_OFS         12'h014
`define PFSA_CFG_OFS         12'h018
`define PFSA_CTL_RD          0
`define PFSA_CTL_WR          1
`define PFSA_CTL_PERMIT      2
`define PFSA_CTL_ABORT       3
`define PFSA_CTL_FREE        4
`define PFSA_CTL_LATCH_ONLY  5
`define PFSA_CTL_CFG_SEL     6
`define PFSA_CTL_BUSY        7
`define PFSA_CFG_PROTECT_N   0
`define PFSA_CFG_WPR_LSB     1
`define PFSA_CFG_RESET       8'h07
`define PFSA_KEY_FIRST       8'h55
`define PFSA_KEY_SECOND      8'haa
`define PFSA_BLANK_WORD      14'h3fff
`define PFSA_ROW_TIME_US     2000
`define PFSA_CLK_MHZ         25
`define PFSA_READ_DELAY      2
`endif

//--- src/pfsa_top.v
// flash self-access sequencer with ahb-lite register slave
`timescale 1ns/1ps
`include "pfsa_regs.vh"
module pfsa_top #(
    parameter ROW_CYCLES = `PFSA_ROW_TIME_US * `PFSA_CLK_MHZ,
    parameter MAIN_WORDS = 32768,
    parameter CFG_WORDS  = 32
) (
    input  wire        sys_clk_i,
    input  wire        rst_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg  [31:0] hrdata_o,
    output wire        hreadyout_o,
    output wire        hresp_o,
    input  wire        ext_prog_req_i,
    input  wire        ext_prog_write_i,
    input  wire        ext_bulk_erase_i,
    input  wire [14:0] ext_addr_i,
    input  wire [13:0] ext_wdata_i,
    output reg  [13:0] ext_rdata_o,
    output reg         ext_denied_o,
    output wire        cpu_stall_o,
    output wire        cpu_force_nop_o
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_RDLY  = 3'd1;
    localparam ST_RACC  = 3'd2;
    localparam ST_WNOP  = 3'd3;
    localparam ST_ROW   = 3'd4;
    localparam ST_LAST  = 3'd5;

    reg [13:0] main_mem [0:MAIN_WORDS-1];
    reg [13:0] cfg_mem  [0:CFG_WORDS-1];
    reg [13:0] latch    [0:31];

    reg [7:0]  flash_addr_low;
    reg [6:0]  flash_addr_high;
    reg [7:0]  flash_data_low;
    reg [5:0]  flash_data_high;
    reg        read_start;
    reg        write_start;
    reg        write_permit_bit;
    reg        write_abort_flag;
    reg        row_erase;
    reg        latch_load_only;
    reg        config_space_select;
    reg        code_protect_n;
    reg [1:0]  write_protect_range;
    reg [1:0]  key_state;
    reg [2:0]  state;
    reg [1:0]  dly;
    reg [31:0] row_cnt;

    reg        dp_valid;
    reg        dp_write;
    reg [11:0] dp_addr;
    integer    i;

    wire [14:0] flash_addr = {flash_addr_high, flash_addr_low};
    wire [13:0] flash_word = {flash_data_high, flash_data_low};
    wire [9:0]  row_base   = flash_addr[14:5];
    wire [4:0]  latch_idx  = flash_addr[4:0];

    function protected_addr;
        input [14:0] a;
        input [1:0]  wrt;
        begin
            case (wrt)
                2'b11:   protected_addr = 1'b0;
                2'b10:   protected_addr = (a < 15'h0200);
                2'b01:   protected_addr = (a < 15'h4000);
                default: protected_addr = 1'b1;
            endcase
        end
    endfunction

    assign hreadyout_o     = 1'b1;
    assign hresp_o         = 1'b0;
    assign cpu_stall_o     = (state == ST_ROW);
    assign cpu_force_nop_o = (state == ST_WNOP) || (state == ST_RDLY) || (state == ST_RACC);

    wire take = hsel_i && hready_i && htrans_i[1];
    wire wr_ctl = dp_valid && dp_write && (dp_addr == `PFSA_CONTROL_OFS);
    wire wr_key = dp_valid && dp_write && (dp_addr == `PFSA_KEY_OFS);

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 12'h000;
        end else begin
            dp_valid <= take;
            dp_write <= hwrite_i;
            dp_addr  <= haddr_i[11:0];
        end
    end

    always @* begin
        hrdata_o = 32'h0000_0000;
        case (dp_addr)
            `PFSA_ADDR_LOW_OFS:  hrdata_o = {24'h000000, flash_addr_low};
            `PFSA_ADDR_HIGH_OFS: hrdata_o = {25'h0000000, flash_addr_high};
            `PFSA_DATA_LOW_OFS:  hrdata_o = {24'h000000, flash_data_low};
            `PFSA_DATA_HIGH_OFS: hrdata_o = {26'h0000000, flash_data_high};
            `PFSA_CONTROL_OFS:   hrdata_o = {24'h000000, cpu_stall_o, config_space_select,
                                  latch_load_only, row_erase, write_abort_flag,
                                  write_permit_bit, write_start, read_start};
            `PFSA_KEY_OFS:       hrdata_o = 32'h0000_0000;
            `PFSA_CFG_OFS:       hrdata_o = {29'h00000000, write_protect_range, code_protect_n};
            default:             hrdata_o = 32'h0000_0000;
        endcase
    end

    // external programmer port
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ext_rdata_o  <= 14'h0000;
            ext_denied_o <= 1'b0;
        end else begin
            ext_denied_o <= ext_prog_req_i && !code_protect_n;
            if (ext_prog_req_i && code_protect_n && !ext_prog_write_i)
                ext_rdata_o <= main_mem[ext_addr_i];
            else
                ext_rdata_o <= 14'h0000;
        end
    end

    always @(posedge sys_clk_i) begin
        if (ext_bulk_erase_i) begin
            for (i = 0; i < MAIN_WORDS; i = i + 1)
                main_mem[i] <= `PFSA_BLANK_WORD;
            for (i = 0; i < CFG_WORDS; i = i + 1)
                cfg_mem[i] <= `PFSA_BLANK_WORD;
        end else if (ext_prog_req_i && ext_prog_write_i && code_protect_n) begin
            main_mem[ext_addr_i] <= main_mem[ext_addr_i] & ext_wdata_i;
        end else if (state == ST_LAST && !row_erase) begin
            for (i = 0; i < 32; i = i + 1)
                if (config_space_select)
                    cfg_mem[i[4:0]] <= cfg_mem[i[4:0]] & latch[i];
                else if (!protected_addr({row_base, i[4:0]}, write_protect_range))
                    main_mem[{row_base, i[4:0]}] <= main_mem[{row_base, i[4:0]}] & latch[i];
        end else if (state == ST_LAST && row_erase && !config_space_select &&
                     !protected_addr(flash_addr, write_protect_range)) begin
            for (i = 0; i < 32; i = i + 1)
                main_mem[{row_base, i[4:0]}] <= `PFSA_BLANK_WORD;
        end
    end

    // configuration bits load from the low bits of an external write to address 7fff
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            code_protect_n      <= |(`PFSA_CFG_RESET & 8'h01);
            write_protect_range <= 2'b11;
        end else if (ext_bulk_erase_i) begin
            code_protect_n      <= 1'b1;
            write_protect_range <= 2'b11;
        end else if (ext_prog_req_i && ext_prog_write_i && ext_addr_i == 15'h7fff) begin
            code_protect_n      <= ext_wdata_i[`PFSA_CFG_PROTECT_N];
            write_protect_range <= ext_wdata_i[`PFSA_CFG_WPR_LSB +: 2];
        end
    end

    wire key_ok    = (key_state == 2'd2);
    wire wr_set    = wr_ctl && hwdata_i[`PFSA_CTL_WR] && state == ST_IDLE;
    wire rd_set    = wr_ctl && hwdata_i[`PFSA_CTL_RD] && state == ST_IDLE && !wr_set;
    wire go_write  = wr_set && key_ok && write_permit_bit;
    wire blocked   = !config_space_select && protected_addr(flash_addr, write_protect_range);

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            // a write interrupted in the row time (ST_ROW) leaves the abort flag raised
            write_abort_flag    <= (state == ST_ROW) || write_abort_flag;
            flash_addr_low      <= 8'h00;
            flash_addr_high     <= 7'h00;
            flash_data_low      <= 8'h00;
            flash_data_high     <= 6'h00;
            read_start          <= 1'b0;
            write_start         <= 1'b0;
            write_permit_bit    <= 1'b0;
            row_erase           <= 1'b0;
            latch_load_only     <= 1'b0;
            config_space_select <= 1'b0;
            key_state           <= 2'd0;
            state               <= ST_IDLE;
            dly                 <= 2'd0;
            row_cnt             <= 32'd0;
            for (i = 0; i < 32; i = i + 1)
                latch[i] <= `PFSA_BLANK_WORD;
        end else begin
            if (dp_valid && dp_write) begin
                case (dp_addr)
                    `PFSA_ADDR_LOW_OFS:  flash_addr_low  <= hwdata_i[7:0];
                    `PFSA_ADDR_HIGH_OFS: flash_addr_high <= hwdata_i[6:0];
                    `PFSA_DATA_LOW_OFS:  flash_data_low  <= hwdata_i[7:0];
                    `PFSA_DATA_HIGH_OFS: flash_data_high <= hwdata_i[5:0];
                    `PFSA_CONTROL_OFS: begin
                        write_permit_bit    <= hwdata_i[`PFSA_CTL_PERMIT];
                        row_erase           <= hwdata_i[`PFSA_CTL_FREE];
                        latch_load_only     <= hwdata_i[`PFSA_CTL_LATCH_ONLY];
                        config_space_select <= hwdata_i[`PFSA_CTL_CFG_SEL];
                        if (!hwdata_i[`PFSA_CTL_ABORT])
                            write_abort_flag <= 1'b0;
                    end
                    default: ;
                endcase
            end
            // key sequence, broken by any other bus write
            if (wr_key && hwdata_i[7:0] == `PFSA_KEY_FIRST)
                key_state <= 2'd1;
            else if (wr_key && key_state == 2'd1 && hwdata_i[7:0] == `PFSA_KEY_SECOND)
                key_state <= 2'd2;
            else if (dp_valid && dp_write && !(wr_ctl && key_ok))
                key_state <= 2'd0;
            else if (wr_ctl)
                key_state <= 2'd0;

            case (state)
                ST_IDLE: begin
                    if (rd_set) begin
                        read_start <= 1'b1;
                        state      <= ST_RDLY;
                    end else if (go_write) begin
                        write_start <= 1'b1;
                        dly         <= 2'd0;
                        state       <= ST_WNOP;
                    end
                end
                ST_RDLY: state <= ST_RACC;
                ST_RACC: begin
                    {flash_data_high, flash_data_low} <= config_space_select ?
                        cfg_mem[flash_addr[4:0]] : main_mem[flash_addr];
                    read_start <= 1'b0;
                    state      <= ST_IDLE;
                end
                ST_WNOP: begin
                    dly <= dly + 2'd1;
                    if (dly == 2'd1) begin
                        if (latch_load_only && !row_erase) begin
                            latch[latch_idx] <= flash_word;
                            write_start      <= 1'b0;
                            state            <= ST_IDLE;
                        end else if (blocked) begin
                            write_start <= 1'b0;
                            state       <= ST_LAST;
                        end else begin
                            // last word of a row program joins the latches
                            if (!row_erase)
                                latch[latch_idx] <= flash_word;
                            row_cnt <= ROW_CYCLES;
                            state   <= ST_ROW;
                        end
                    end
                end
                ST_ROW: begin
                    if (row_cnt <= 32'd1)
                        state <= ST_LAST;
                    else
                        row_cnt <= row_cnt - 32'd1;
                end
                ST_LAST: begin
                    for (i = 0; i < 32; i = i + 1)
                        latch[i] <= `PFSA_BLANK_WORD;
                    write_start <= 1'b0;
                    state       <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- verification/pfsa_checker.sv
// concurrent checks on the flash self-access ports
`timescale 1ns/1ps
module pfsa_checker #(
    parameter ROW_CYCLES = 20
) (
    input wire        sys_clk_i,
    input wire        rst_i,
    input wire        hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire [31:0] hwdata_i,
    input wire        hready_i,
    input wire [31:0] hrdata_o,
    input wire        hresp_o,
    input wire        ext_prog_req_i,
    input wire [13:0] ext_rdata_o,
    input wire        ext_denied_o,
    input wire        cpu_stall_o,
    input wire        cpu_force_nop_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    reg        ctl_wr;
    reg        key_rd;
    reg [15:0] stall_len;
    wire       take = hsel_i && hready_i && htrans_i[1];
    // flags mark the data phase of an access taken one edge earlier
    always @(posedge sys_clk_i) begin
        ctl_wr <= take && hwrite_i && haddr_i[11:0] == 12'h010;
        key_rd <= take && !hwrite_i && haddr_i[11:0] == 12'h014;
        stall_len <= cpu_stall_o ? stall_len + 16'h1 : 16'h0;
    end
    property p_okay;
        hresp_o == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_key_zero;
        key_rd |-> hrdata_o == 32'h0;
    endproperty
    a_key_zero: assert property (p_key_zero) else $error("key read not zero");
    property p_deny_blank;
        ext_denied_o |-> ext_rdata_o == 14'h0;
    endproperty
    a_deny_blank: assert property (p_deny_blank) else $error("denied read leaks");
    property p_deny_cause;
        ext_denied_o |-> $past(ext_prog_req_i);
    endproperty
    a_deny_cause: assert property (p_deny_cause) else $error("denial without request");
    property p_stall_min;
        $rose(cpu_stall_o) |-> cpu_stall_o [*8];
    endproperty
    a_stall_min: assert property (p_stall_min) else $error("stall too short");
    property p_stall_max;
        stall_len <= ROW_CYCLES + 4;
    endproperty
    a_stall_max: assert property (p_stall_max) else $error("stall too long");
    property p_read_nop;
        ctl_wr && hwdata_i[0] && !cpu_stall_o && !cpu_force_nop_o |-> ##[1:3] cpu_force_nop_o;
    endproperty
    a_read_nop: assert property (p_read_nop) else $error("read slot not taken");
    property p_quiet_reset;
        $fell(rst_i) |-> !cpu_stall_o && !cpu_force_nop_o;
    endproperty
    a_quiet_reset: assert property (p_quiet_reset) else $error("busy after reset");
endmodule
bind pfsa_top pfsa_checker #(.ROW_CYCLES(ROW_CYCLES)) u_chk (.*);

//--- verification/pfsa_prog_model.sv
// external device programmer model on the programming port
`timescale 1ns/1ps
module pfsa_prog_model (
    input  wire         clk_i,
    input  wire  [13:0] rdata_i,
    input  wire         denied_i,
    output logic        req_o = 1'b0,
    output logic        write_o = 1'b0,
    output logic        bulk_o = 1'b0,
    output logic [14:0] addr_o = 15'h0,
    output logic [13:0] wdata_o = 14'h0
);
    task automatic access(input logic w, input logic [14:0] a, input logic [13:0] d,
                          output logic [13:0] q, output logic dn);
        @(posedge clk_i);
        req_o <= 1'b1;
        write_o <= w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        req_o <= 1'b0;
        write_o <= 1'b0;
        // released lines show the inverse, never the old value
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        q = rdata_i;
        dn = denied_i;
    endtask
    task automatic bulk;
        @(posedge clk_i);
        bulk_o <= 1'b1;
        @(posedge clk_i);
        bulk_o <= 1'b0;
    endtask
endmodule

//--- verification/pfsa_top_tb.sv
// self-checking bench for the flash self-access block
`timescale 1ns/1ps
module pfsa_top_tb;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, hready, hresp, req, pw, bulk, denied, stall, fnop;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [14:0] xaddr;
    logic [13:0] xwd, xrd, q;
    logic        dn;
    int          n_mismatch = 0, tests_run = 0, stall_cnt = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (stall === 1'b1) stall_cnt++;
    pfsa_top #(.ROW_CYCLES(20)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .ext_prog_req_i(req), .ext_prog_write_i(pw), .ext_bulk_erase_i(bulk),
        .ext_addr_i(xaddr), .ext_wdata_i(xwd), .ext_rdata_o(xrd), .ext_denied_o(denied),
        .cpu_stall_o(stall), .cpu_force_nop_o(fnop));
    pfsa_prog_model u_prog (.clk_i(sys_clk_i), .rdata_i(xrd), .denied_i(denied), .req_o(req),
        .write_o(pw), .bulk_o(bulk), .addr_o(xaddr), .wdata_o(xwd));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t ns: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        v = hrdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(v & {24'hffffff, m}, e);
    endtask
    task automatic idle;
        int k;
        k = 0;
        do begin
            bus(1'b0, 12'h010, 32'h0);
            k++;
        end while ((v & 32'h83) !== 32'h0 && k < 100);
        if (k == 100) n_mismatch++;
    endtask
    task automatic start(input logic [14:0] a, input logic [13:0] d, input logic [7:0] c,
                         input logic brk);
        bus(1'b1, 12'h000, a[7:0]);
        bus(1'b1, 12'h004, a[14:8]);
        bus(1'b1, 12'h008, d[7:0]);
        bus(1'b1, 12'h00c, d[13:8]);
        bus(1'b1, 12'h010, c);
        bus(1'b1, 12'h014, 32'h55);
        if (brk) bus(1'b1, 12'h008, d[7:0]);
        bus(1'b1, 12'h014, 32'haa);
        stall_cnt = 0;
        bus(1'b1, 12'h010, c | 8'h02);
    endtask
    task automatic prog(input logic [14:0] a, input logic [13:0] d, input logic [7:0] c,
                        input logic brk);
        start(a, d, c, brk);
        idle;
    endtask
    task automatic fetch(input logic [14:0] a, input logic [13:0] e);
        logic [7:0] lo;
        bus(1'b1, 12'h000, a[7:0]);
        bus(1'b1, 12'h004, a[14:8]);
        bus(1'b1, 12'h010, 32'h0);
        bus(1'b1, 12'h010, 32'h1);
        idle;
        bus(1'b0, 12'h008, 32'h0);
        lo = v[7:0];
        bus(1'b0, 12'h00c, 32'h0);
        chk({v[5:0], lo}, e);
    endtask
    task automatic xchk(input logic [14:0] a, input logic [13:0] e, input logic ed);
        u_prog.access(1'b0, a, 14'h0, q, dn);
        chk({dn, q}, {ed, e});
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #1200000;
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(12'h010, 8'hff, 32'h0);
        rdc(12'h014, 8'hff, 32'h0);
        rdc(12'h018, 8'h07, 32'h7);
        rdc(12'h01c, 8'hff, 32'h0);
        u_prog.bulk;
        $display("test reset values done");
        prog(15'h045, 14'h0, 8'h00, 1'b0);
        chk(stall_cnt, 0);
        prog(15'h046, 14'h0, 8'h04, 1'b1);
        chk(stall_cnt, 0);
        rdc(12'h010, 8'h02, 32'h0);
        prog(15'h041, 14'h0abc, 8'h24, 1'b0);
        chk(stall_cnt, 0);
        prog(15'h042, 14'h1555, 8'h04, 1'b0);
        chk(stall_cnt > 0, 1);
        prog(15'h060, 14'h0123, 8'h04, 1'b0);
        fetch(15'h041, 14'h0abc);
        fetch(15'h042, 14'h1555);
        fetch(15'h043, 14'h3fff);
        fetch(15'h045, 14'h3fff);
        fetch(15'h046, 14'h3fff);
        rdc(12'h00c, 8'hff, 32'h3f);
        bus(1'b1, 12'h008, 32'h12);
        rdc(12'h008, 8'hff, 32'h12);
        rdc(12'h00c, 8'hff, 32'h3f);
        $display("test latch and program done");
        prog(15'h043, 14'h2222, 8'h04, 1'b0);
        fetch(15'h043, 14'h2222);
        prog(15'h05f, 14'h0, 8'h14, 1'b0);
        chk(stall_cnt > 0, 1);
        fetch(15'h043, 14'h3fff);
        fetch(15'h060, 14'h0123);
        $display("test erase done");
        u_prog.access(1'b1, 15'h7fff, 14'h3ff9, q, dn);
        rdc(12'h018, 8'h07, 32'h1);
        prog(15'h044, 14'h0, 8'h04, 1'b0);
        fetch(15'h044, 14'h3fff);
        u_prog.access(1'b1, 15'h044, 14'h0aaa, q, dn);
        xchk(15'h044, 14'h0aaa, 1'b0);
        u_prog.access(1'b1, 15'h7fff, 14'h3ff8, q, dn);
        xchk(15'h060, 14'h0, 1'b1);
        fetch(15'h060, 14'h0123);
        u_prog.bulk;
        rdc(12'h018, 8'h07, 32'h7);
        xchk(15'h060, 14'h3fff, 1'b0);
        $display("test protection done");
        start(15'h042, 14'h0, 8'h04, 1'b0);
        bus(1'b1, 12'h010, 32'h04);
        rdc(12'h010, 8'h02, 32'h2);
        rst_i <= 1'b1;
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(12'h010, 8'hff, 32'h08);
        $display("test write abort done");
        tally_and_finish;
    end
endmodule
